// [logic/adc_seq_pkg.sv]
// shared constants for the conversion sequencer
`default_nettype none
package adc_seq_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL_A  = 8'h00;
	localparam logic [7:0] OFF_CTRL_B  = 8'h04;
	localparam logic [7:0] OFF_RESULT  = 8'h08;
	localparam logic [7:0] OFF_STATUS  = 8'h0c;
	localparam logic [7:0] OFF_MASK    = 8'h10;
	localparam logic [7:0] OFF_INTEN   = 8'h14;
	// control a fields
	localparam int POS_CHAN   = 0;
	localparam int POS_SRC    = 4;
	localparam int POS_FMT    = 7;
	localparam int POS_PWR    = 8;
	localparam int POS_START  = 9;
	localparam int POS_BUSY   = 10;
	// control b fields
	localparam int POS_DIV    = 0;
	localparam int POS_REF    = 4;
	// interrupt enable fields
	localparam int POS_GIE    = 0;
	localparam int POS_CIE    = 1;
	// reset values
	localparam logic [31:0] RST_CTRL_A = 32'h0000_0000;
	localparam logic [31:0] RST_CTRL_B = 32'h0000_0000;
	// conversion timing in converter clocks
	localparam logic [4:0] SAMPLE_CYCLES  = 5'h04;
	localparam logic [4:0] CONVERT_CYCLES = 5'h0c;
	localparam logic [4:0] TOTAL_CYCLES   = 5'h10;
	localparam int         RESULT_BITS    = 12;
	localparam logic [11:0] FULL_SCALE    = 12'hfff;
	// source select code for external input
	localparam logic [2:0] SRC_EXTERNAL   = 3'h0;
	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		CV_IDLE   = 2'b00,
		CV_ARMED  = 2'b01,
		CV_SAMPLE = 2'b10,
		CV_CONV   = 2'b11
	} conv_state_e;
endpackage
`default_nettype wire

// [logic/adc_clock_divider.sv]
// power of two tick generator for the converter clock
`default_nettype none
module adc_clock_divider (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	// control
	input  wire logic       run_i,
	input  wire logic [2:0] div_code_i,
	// tick output
	output logic            tick_o
);
	logic [6:0] count;

	// code n divides by 2**n; counter restarts whenever not running
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count  <= 7'h00;
			tick_o <= 1'b0;
		end else if (!run_i) begin
			count  <= 7'h00;
			tick_o <= 1'b0;
		end else if (count >= ((7'h01 << div_code_i) - 7'h01)) begin
			count  <= 7'h00;
			tick_o <= 1'b1;
		end else begin
			count  <= count + 7'h01;
			tick_o <= 1'b0;
		end
	end
endmodule // adc_clock_divider
`default_nettype wire

// [logic/adc_conversion_core.sv]
// sixteen tick sample and convert sequence, result capture
`default_nettype none
module adc_conversion_core
	import adc_seq_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	// control
	input  wire logic                  power_i,
	input  wire logic                  arm_i,
	input  wire logic                  go_i,
	input  wire logic                  tick_i,
	input  wire logic [RESULT_BITS-1:0] sample_i,
	// status
	output logic                       busy_o,
	output logic                       done_o,
	output logic [RESULT_BITS-1:0]     result_o
);
	conv_state_e state;
	logic [4:0]  ticks;

	// sequencing; power loss aborts any conversion in flight
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state    <= CV_IDLE;
			ticks    <= 5'h00;
			busy_o   <= 1'b0;
			done_o   <= 1'b0;
			result_o <= 12'h000;
		end else begin
			done_o <= 1'b0;
			if (!power_i) begin
				state  <= CV_IDLE;
				busy_o <= 1'b0;
			end else if (arm_i) begin
				state  <= CV_ARMED;
				ticks  <= 5'h00;
				busy_o <= 1'b0;
			end else begin
				unique case (state)
					CV_IDLE: begin
					end
					CV_ARMED: begin
						if (go_i) begin
							state  <= CV_SAMPLE;
							busy_o <= 1'b1;
							ticks  <= 5'h00;
						end
					end
					CV_SAMPLE: begin
						if (tick_i) begin
							ticks <= ticks + 5'h01;
							if (ticks == SAMPLE_CYCLES - 5'h01) begin
								result_o <= sample_i; // sampled value held through conversion
								state    <= CV_CONV;
							end
						end
					end
					CV_CONV: begin
						if (tick_i) begin
							ticks <= ticks + 5'h01;
							if (ticks == TOTAL_CYCLES - 5'h01) begin
								state  <= CV_IDLE;
								busy_o <= 1'b0;
								done_o <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end
endmodule // adc_conversion_core
`default_nettype wire

// [logic/adc_conversion_sequencer.sv]
// axi4-lite controlled conversion sequencer top level
//
// Contract
// - external source routes selected channel (low three select bits) only while power enable is high
// - internal source disconnects all external channels
// - four-bit reference source selection
// - format bit arranges high/low result bytes
// - busy high throughout conversion
// - completion clears busy, publishes result
// - interrupt needs global and converter enable
// - power enable low powers converter off
// - twelve-bit result, full scale all ones
// - four sample plus twelve convert ticks
// - divider power of two, 1 to 128
// - completion sets interrupt request flag
`default_nettype none
module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// axi4-lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// analog front end
	input  wire logic [11:0] sample_data_i,
	output logic [7:0]       channel_connect_o,
	output logic [2:0]       internal_source_o,
	output logic [3:0]       reference_source_select_o,
	output logic             converter_power_o,
	// interrupt
	output logic             irq_o
);
	// control a fields
	logic [3:0]  external_channel_select;
	logic [2:0]  input_source_select;
	logic        result_format_select;
	logic        converter_power_enable;
	logic        start_bit;
	// control b fields
	logic [2:0]  converter_clock_divider;
	logic [3:0]  reference_source_select;
	// interrupt state
	logic        converter_interrupt_request;
	logic        converter_interrupt_mask;
	logic        global_interrupt_enable;
	logic        converter_interrupt_enable;
	// bus holding
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic [31:0] ctrl_a_now;
	logic [31:0] ctrl_a_merged;
	// core links
	logic        start_prev;
	logic        arm;
	logic        go;
	logic        tick;
	logic        conversion_busy_flag;
	logic        done;
	logic [11:0] raw_result;
	logic [7:0]  result_high_byte;
	logic [7:0]  result_low_byte;
	logic        armed_copy;

	// merge byte lanes into an old register value
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// current control a word, shared by the read path and by partial lane writes
	assign ctrl_a_now    = {21'h0, conversion_busy_flag, start_bit, converter_power_enable, result_format_select,
		input_source_select, external_channel_select};
	assign ctrl_a_merged = lane_merge(ctrl_a_now, w_data, w_strb);

	// write channel capture: address and data in either order
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// ready flags: one write outstanding keeps the slave simple
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid && !do_write;
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid && !do_write;
		end
	end

	// write response
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			unique case (aw_addr & 8'hfc)
				OFF_CTRL_A, OFF_CTRL_B, OFF_RESULT, OFF_STATUS, OFF_MASK, OFF_INTEN: s_axi_bresp <= RESP_OKAY;
				default: s_axi_bresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control a register; start bit level is kept as written
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			external_channel_select <= RST_CTRL_A[POS_CHAN +: 4];
			input_source_select     <= RST_CTRL_A[POS_SRC +: 3];
			result_format_select    <= RST_CTRL_A[POS_FMT];
			converter_power_enable  <= RST_CTRL_A[POS_PWR];
			start_bit               <= RST_CTRL_A[POS_START];
		end else if (do_write && (aw_addr & 8'hfc) == OFF_CTRL_A) begin
			external_channel_select <= ctrl_a_merged[POS_CHAN +: 4];
			input_source_select     <= ctrl_a_merged[POS_SRC +: 3];
			result_format_select    <= ctrl_a_merged[POS_FMT];
			converter_power_enable  <= ctrl_a_merged[POS_PWR];
			start_bit               <= ctrl_a_merged[POS_START];
		end
	end

	// control b register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			converter_clock_divider <= RST_CTRL_B[POS_DIV +: 3];
			reference_source_select <= RST_CTRL_B[POS_REF +: 4];
		end else if (do_write && (aw_addr & 8'hfc) == OFF_CTRL_B && w_strb[0]) begin
			converter_clock_divider <= w_data[POS_DIV +: 3];
			reference_source_select <= w_data[POS_REF +: 4];
		end
	end

	// interrupt flag: completion wins over a write-one clear in the same cycle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			converter_interrupt_request <= 1'b0;
		end else if (done) begin
			converter_interrupt_request <= 1'b1;
		end else if (do_write && (aw_addr & 8'hfc) == OFF_STATUS && w_strb[0] && w_data[0]) begin
			converter_interrupt_request <= 1'b0;
		end
	end

	// mask and enables
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			converter_interrupt_mask   <= 1'b0;
			global_interrupt_enable    <= 1'b0;
			converter_interrupt_enable <= 1'b0;
		end else if (do_write && w_strb[0]) begin
			if ((aw_addr & 8'hfc) == OFF_MASK) begin
				converter_interrupt_mask <= w_data[0];
			end
			if ((aw_addr & 8'hfc) == OFF_INTEN) begin
				global_interrupt_enable    <= w_data[POS_GIE];
				converter_interrupt_enable <= w_data[POS_CIE];
			end
		end
	end

	// interrupt output needs flag, mask and both enables; polling leaves them low
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= converter_interrupt_request && converter_interrupt_mask && global_interrupt_enable &&
				converter_interrupt_enable;
		end
	end

	// start edge detection on the software level
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_prev <= 1'b0;
		end else begin
			start_prev <= start_bit;
		end
	end

	assign arm = start_bit && !start_prev;
	assign go  = !start_bit && start_prev;

	// copy of the core's armed state, used only by the start check
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			armed_copy <= 1'b0;
		end else begin
			armed_copy <= converter_power_enable && !go && (arm || armed_copy);
		end
	end

	// converter clock source
	adc_clock_divider u_div (
		.clk_i      (clk_i),
		.reset_n_i  (reset_n_i),
		.run_i      (conversion_busy_flag),
		.div_code_i (converter_clock_divider),
		.tick_o     (tick)
	);

	// sample and convert sequence
	adc_conversion_core u_core (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.power_i   (converter_power_enable),
		.arm_i     (arm),
		.go_i      (go),
		.tick_i    (tick),
		.sample_i  (sample_data_i),
		.busy_o    (conversion_busy_flag),
		.done_o    (done),
		.result_o  (raw_result)
	);

	// result registers updated only at completion so reads stay stable
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			result_high_byte <= 8'h00;
			result_low_byte  <= 8'h00;
		end else if (done) begin
			if (result_format_select) begin
				result_high_byte <= {4'h0, raw_result[11:8]};
				result_low_byte  <= raw_result[7:0];
			end else begin
				result_high_byte <= raw_result[11:4];
				result_low_byte  <= {raw_result[3:0], 4'h0};
			end
		end
	end

	// analog routing and power, all registered
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			channel_connect_o         <= 8'h00;
			internal_source_o         <= 3'h0;
			reference_source_select_o <= 4'h0;
			converter_power_o         <= 1'b0;
		end else begin
			converter_power_o         <= converter_power_enable;
			reference_source_select_o <= reference_source_select;
			if (converter_power_enable && input_source_select == SRC_EXTERNAL) begin
				channel_connect_o <= 8'h01 << external_channel_select[2:0];
				internal_source_o <= 3'h0;
			end else begin
				channel_connect_o <= 8'h00;
				internal_source_o <= converter_power_enable ? input_source_select : 3'h0;
			end
		end
	end

	// read channel
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				unique case (s_axi_araddr & 8'hfc)
					OFF_CTRL_A: s_axi_rdata <= ctrl_a_now;
					OFF_CTRL_B: s_axi_rdata <= {24'h0, reference_source_select, 1'b0, converter_clock_divider};
					OFF_RESULT: s_axi_rdata <= {16'h0, result_high_byte, result_low_byte};
					OFF_STATUS: s_axi_rdata <= {31'h0, converter_interrupt_request};
					OFF_MASK:   s_axi_rdata <= {31'h0, converter_interrupt_mask};
					OFF_INTEN:  s_axi_rdata <= {30'h0, converter_interrupt_enable, global_interrupt_enable};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// busy must be high in the cycle after a powered, armed start
	AST_BUSY_ON_GO: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(go && armed_copy && converter_power_enable) |=> conversion_busy_flag)
		else $error("busy not raised after start");
	AST_DONE_CLEARS_BUSY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		done |-> !conversion_busy_flag)
		else $error("busy still high at completion");
	AST_FLAG_ON_DONE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		done |=> converter_interrupt_request)
		else $error("request flag not set on completion");
	AST_IRQ_GATED: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		irq_o |-> $past(global_interrupt_enable) && $past(converter_interrupt_enable))
		else $error("interrupt without both enables");
	AST_INTERNAL_DISCONNECT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$past(input_source_select) != SRC_EXTERNAL |-> channel_connect_o == 8'h00)
		else $error("external channel connected on internal source");
	AST_POWER_OFF: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!converter_power_enable |=> !converter_power_o && !conversion_busy_flag)
		else $error("converter powered while disabled");
	AST_RESULT_FORMAT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(done && result_format_select) |=> result_high_byte[7:4] == 4'h0)
		else $error("right justified high byte has upper bits");
	AST_BUSY_LENGTH: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$rose(conversion_busy_flag) && converter_clock_divider == 3'h0 && converter_power_enable |->
		(conversion_busy_flag || !converter_power_o) [*8])
		else $error("conversion ended too early while powered");
endmodule // adc_conversion_sequencer
`default_nettype wire

// [verification/adc_conversion_sequencer_test.sv]
// register level bench for the conversion sequencer
`default_nettype none
module adc_conversion_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_seq_pkg::*;

	localparam logic [31:0] PWR = 32'h1 << POS_PWR;

	// bench driven inputs, all defined at time zero
	logic        clk_i     = 1'h0;
	logic        reset_n_i = 1'h0;
	logic        aw_v      = 1'h0;
	logic        w_v       = 1'h0;
	logic        b_r       = 1'h0;
	logic        ar_v      = 1'h0;
	logic        r_r       = 1'h0;
	logic [7:0]  aw_a      = 8'h0;
	logic [7:0]  ar_a      = 8'h0;
	logic [31:0] w_d       = 32'h0;
	logic [11:0] sample    = 12'h0;
	// design outputs
	logic        aw_r;
	logic        w_r;
	logic        b_v;
	logic        ar_r;
	logic        r_v;
	logic        irq;
	logic        pwr_o;
	logic [1:0]  b_resp;
	logic [1:0]  r_resp;
	logic [31:0] r_d;
	logic [7:0]  ch;
	logic [2:0]  isrc;
	logic [3:0]  vref;
	// interrupt enable walk: address, data, expected line level
	logic [7:0]  ta [6] = '{OFF_INTEN, OFF_MASK, OFF_MASK, OFF_INTEN, OFF_INTEN, OFF_STATUS};
	logic [3:0]  td [6] = '{4'h3, 4'h0, 4'h1, 4'h2, 4'h3, 4'h1};
	logic        ti [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
	int          n_errors = 0;
	int          compares = 0;
	int          cyc      = 0;

	adc_conversion_sequencer adc_conversion_sequencer_inst (
		.clk_i                     (clk_i),
		.reset_n_i                 (reset_n_i),
		.s_axi_awvalid             (aw_v),
		.s_axi_awready             (aw_r),
		.s_axi_awaddr              (aw_a),
		.s_axi_wvalid              (w_v),
		.s_axi_wready              (w_r),
		.s_axi_wdata               (w_d),
		.s_axi_wstrb               (4'hf),
		.s_axi_bvalid              (b_v),
		.s_axi_bready              (b_r),
		.s_axi_bresp               (b_resp),
		.s_axi_arvalid             (ar_v),
		.s_axi_arready             (ar_r),
		.s_axi_araddr              (ar_a),
		.s_axi_rvalid              (r_v),
		.s_axi_rready              (r_r),
		.s_axi_rdata               (r_d),
		.s_axi_rresp               (r_resp),
		.sample_data_i             (sample),
		.channel_connect_o         (ch),
		.internal_source_o         (isrc),
		.reference_source_select_o (vref),
		.converter_power_o         (pwr_o),
		.irq_o                     (irq)
	);

	// free running clock and a cycle count for duration checks
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares=%0d errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// address and data offered together, each dropped at its own handshake; only the watchdog ends a wait
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_i);
		aw_v <= 1'h1;
		aw_a <= a;
		w_v <= 1'h1;
		w_d <= d;
		b_r <= 1'h1;
		@(posedge clk_i);
		while (aw_v || w_v) begin
			if (aw_v && aw_r === 1'h1) aw_v <= 1'h0;
			if (w_v && w_r === 1'h1) w_v <= 1'h0;
			@(posedge clk_i);
		end
		while (b_v !== 1'h1) @(posedge clk_i);
		b_r <= 1'h0;
		chk({30'h0, b_resp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge clk_i);
		ar_v <= 1'h1;
		ar_a <= a;
		r_r <= 1'h1;
		@(posedge clk_i);
		while (ar_r !== 1'h1) @(posedge clk_i);
		ar_v <= 1'h0;
		while (r_v !== 1'h1) @(posedge clk_i);
		d = r_d;
		r_r <= 1'h0;
		chk({30'h0, r_resp}, {30'h0, er});
	endtask

	// start pulse, then poll busy; a held high start must not convert
	task automatic convert(input logic [31:0] ca, input logic [11:0] s, output int dur);
		logic [31:0] v;
		int t0;
		int i;
		sample <= s;
		wr(OFF_CTRL_A, ca | 32'h1 << POS_START, RESP_OKAY);
		tick(20);
		rd(OFF_CTRL_A, v, RESP_OKAY);
		chk({31'h0, v[POS_BUSY]}, 32'h0);
		wr(OFF_CTRL_A, ca, RESP_OKAY);
		t0 = cyc;
		tick(4);
		rd(OFF_CTRL_A, v, RESP_OKAY);
		chk({31'h0, v[POS_BUSY]}, 32'h1);
		for (i = 0; i < 1000 && v[POS_BUSY] === 1'h1; i++) begin
			rd(OFF_CTRL_A, v, RESP_OKAY);
		end
		dur = cyc - t0;
	endtask

	// watchdog: the whole run needs well under ten thousand cycles
	initial begin
		#500000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		logic [31:0] v;
		logic [11:0] s;
		logic        f;
		int          k;
		int          dur;
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'h1;
		tick(2);
		rd(OFF_CTRL_A, v, RESP_OKAY);
		chk(v, RST_CTRL_A);
		rd(OFF_CTRL_B, v, RESP_OKAY);
		chk(v, RST_CTRL_B);
		rd(8'h18, v, RESP_SLVERR);
		wr(8'h18, 32'h1, RESP_SLVERR);
		$display("test reset_and_unmapped done");

		// every channel with power on, reference code changing alongside
		for (k = 0; k < 8; k++) begin
			wr(OFF_CTRL_A, PWR | k, RESP_OKAY);
			wr(OFF_CTRL_B, k << (POS_REF + 1) | 32'h1 << POS_REF, RESP_OKAY);
			tick(2);
			chk({24'h0, ch}, 32'h1 << k);
			chk({28'h0, vref}, k * 2 + 1);
			rd(OFF_CTRL_A, v, RESP_OKAY);
			chk(v, PWR | k);
			rd(OFF_CTRL_B, v, RESP_OKAY);
			chk(v, k << (POS_REF + 1) | 32'h1 << POS_REF);
		end
		wr(OFF_CTRL_A, 32'h5, RESP_OKAY);
		tick(2);
		chk({24'h0, ch}, 32'h0);
		chk({31'h0, pwr_o}, 32'h0);
		wr(OFF_CTRL_A, PWR | 32'h3 << POS_SRC | 32'h5, RESP_OKAY);
		tick(2);
		chk({24'h0, ch}, 32'h0);
		chk({29'h0, isrc}, 32'h3);
		chk({31'h0, pwr_o}, 32'h1);
		$display("test routing done");

		// all divider codes back to back, both result formats
		for (k = 0; k < 8; k++) begin
			s = FULL_SCALE ^ 12'(k * 291);
			f = k[0];
			wr(OFF_CTRL_B, k, RESP_OKAY);
			convert(PWR | 32'(f) << POS_FMT | 32'h2, s, dur);
			chk({31'h0, dur >= 15 << k && dur <= (17 << k) + 10}, 32'h1);
			rd(OFF_RESULT, v, RESP_OKAY);
			chk(v, f ? {20'h0, s} : {16'h0, s, 4'h0});
			rd(OFF_STATUS, v, RESP_OKAY);
			chk(v & 32'h1, 32'h1);
			chk({31'h0, irq}, 32'h0);
			wr(OFF_STATUS, 32'h1, RESP_OKAY);
			rd(OFF_STATUS, v, RESP_OKAY);
			chk(v & 32'h1, 32'h0);
		end
		$display("test conversions done");

		// line needs flag, mask, global and converter enables together
		wr(OFF_MASK, 32'h1, RESP_OKAY);
		wr(OFF_INTEN, 32'h1, RESP_OKAY);
		convert(PWR, 12'h5a3, dur);
		tick(2);
		chk({31'h0, irq}, 32'h0);
		for (k = 0; k < 6; k++) begin
			wr(ta[k], {28'h0, td[k]}, RESP_OKAY);
			tick(2);
			chk({31'h0, irq}, {31'h0, ti[k]});
		end
		$display("test interrupt done");

		// power removed in mid conversion leaves nothing behind; fastest divider so a missed abort would finish
		wr(OFF_CTRL_B, 32'h0, RESP_OKAY);
		wr(OFF_CTRL_A, PWR | 32'h1 << POS_START, RESP_OKAY);
		wr(OFF_CTRL_A, PWR, RESP_OKAY);
		wr(OFF_CTRL_A, 32'h0, RESP_OKAY);
		rd(OFF_CTRL_A, v, RESP_OKAY);
		chk(v, 32'h0);
		tick(40);
		rd(OFF_STATUS, v, RESP_OKAY);
		chk(v & 32'h1, 32'h0);
		$display("test power_abort done");
		report_and_stop();
	end
endmodule // adc_conversion_sequencer_test
`default_nettype wire
